// ---- rtl/sbcint_pkg.sv ----
/*
 * Shared constants and types of the interrupt output block.
 * Assumes a 25 MHz reference clock; all times derive from it.
 */
package sbcint_pkg;

	// ********************************************
	// clock and times
	// ********************************************
	localparam int CLK_KHZ        = 25000;
	localparam int PULSE_US       = 100;
	localparam int GAP_US         = 100;
	localparam int CFG_FILT_US    = 7;
	localparam int WAKE_SHORT_US  = 16;
	localparam int WAKE_LONG_US   = 64;
	localparam int CNT_W          = 12;

	localparam logic [CNT_W-1:0] PULSE_CYC =
		CNT_W'(PULSE_US * CLK_KHZ / 1000);
	localparam logic [CNT_W-1:0] GAP_CYC =
		CNT_W'(GAP_US * CLK_KHZ / 1000);
	localparam logic [CNT_W-1:0] CFG_FILT_CYC =
		CNT_W'(CFG_FILT_US * CLK_KHZ / 1000);
	localparam logic [CNT_W-1:0] WAKE_SHORT_CYC =
		CNT_W'(WAKE_SHORT_US * CLK_KHZ / 1000);
	localparam logic [CNT_W-1:0] WAKE_LONG_CYC =
		CNT_W'(WAKE_LONG_US * CLK_KHZ / 1000);

	// ********************************************
	// status layout
	// ********************************************
	localparam int WAKE_A_W = 3;
	localparam int WAKE_B_W = 2;
	localparam int WAKE_N   = WAKE_A_W + WAKE_B_W;
	localparam int FAIL_W   = 8;
	// bits 0..4: undervoltage, watchdog, short, thermal 2, failure
	localparam logic [FAIL_W-1:0] FAIL_NOINT_MASK = 8'h1F;
	localparam logic [FAIL_W-1:0] FAIL_RST        = 8'h00;
	localparam logic             INT_GLOBAL_RST  = 1'b0;
	localparam logic             CFG_LVL_RST     = 1'b0;

	// ********************************************
	// wake filter selection
	// ********************************************
	localparam logic [1:0] FLT_STATIC_SHORT = 2'h0;
	localparam logic [1:0] FLT_STATIC_LONG  = 2'h1;
	localparam logic [1:0] FLT_CYCLIC_T1    = 2'h2;
	localparam logic [1:0] FLT_CYCLIC_T2    = 2'h3;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_PULSE,
		ST_GAP
	} sbcint_st_e;

endpackage : sbcint_pkg

// ---- rtl/sbcint_wake_if.sv ----
/*
 * Carries wake pins, filter setting and filtered results.
 * Assumes both ends run on the reference clock.
 */
`timescale 1ns/10ps
interface sbcint_wake_if;
	logic [1:0]                   filt_sel;
	logic                         cyc_t1;
	logic                         cyc_t2;
	logic [sbcint_pkg::WAKE_N-1:0] pin;
	logic [sbcint_pkg::WAKE_N-1:0] lvl;
	logic [sbcint_pkg::WAKE_N-1:0] evt;

	modport ctrl (output filt_sel, cyc_t1, cyc_t2, pin,
		input lvl, evt);
	modport filt (input filt_sel, cyc_t1, cyc_t2, pin,
		output lvl, evt);
endinterface : sbcint_wake_if

// ---- rtl/sbcint_wake_filt.sv ----
/*
 * Wake input filters, one counter per input.
 * Assumes pins are already synchronous to the reference clock.
 */
`timescale 1ns/10ps
module sbcint_wake_filt (
	// clock and reset
	input  wire logic i_ref_clk,
	input  wire logic i_reset_n,
	// wake channel
	sbcint_wake_if.filt wk
);
	localparam int N = sbcint_pkg::WAKE_N;
	localparam int W = sbcint_pkg::CNT_W;

	typedef struct packed {
		logic [N-1:0][W-1:0] cnt;
		logic [N-1:0]        lvl;
		logic [N-1:0]        evt;
	} sbcint_wf_s;

	sbcint_wf_s st_reg;
	sbcint_wf_s st_next;
	logic [W-1:0] term;
	logic         run;

	always_comb begin
		st_next = st_reg;
		st_next.evt = '0;
		term = (wk.filt_sel == sbcint_pkg::FLT_STATIC_LONG) ?
			sbcint_pkg::WAKE_LONG_CYC : sbcint_pkg::WAKE_SHORT_CYC;
		// cyclic sense only looks while its timer has the supply on
		case (wk.filt_sel)
			sbcint_pkg::FLT_CYCLIC_T1: run = wk.cyc_t1;
			sbcint_pkg::FLT_CYCLIC_T2: run = wk.cyc_t2;
			default:                   run = 1'b1;
		endcase
		for (int i = 0; i < N; i++) begin
			if (wk.pin[i] == st_reg.lvl[i]) begin
				st_next.cnt[i] = '0;
			end else if (run) begin
				if (st_reg.cnt[i] == term - 1'b1) begin
					st_next.lvl[i] = wk.pin[i];
					st_next.cnt[i] = '0;
					st_next.evt[i] = 1'b1;
				end else begin
					st_next.cnt[i] = st_reg.cnt[i] + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign wk.lvl = st_reg.lvl;
	assign wk.evt = st_reg.evt;

endmodule : sbcint_wake_filt

// ---- rtl/sbcint_cfg_filt.sv ----
/*
 * Filters the level on the interrupt pin during init mode.
 * Assumes the pin input is synchronous to the reference clock.
 */
`timescale 1ns/10ps
module sbcint_cfg_filt (
	// clock and reset
	input  wire logic i_ref_clk,
	input  wire logic i_reset_n,
	// sampling
	input  wire logic i_init_mode,
	input  wire logic i_pin,
	// result
	output logic      o_cfg_lvl
);
	typedef struct packed {
		logic [sbcint_pkg::CNT_W-1:0] cnt;
		logic                         lvl;
	} sbcint_cf_s;

	sbcint_cf_s st_reg;
	sbcint_cf_s st_next;

	always_comb begin
		st_next = st_reg;
		// level is frozen once init mode is left
		if (!i_init_mode || i_pin == st_reg.lvl) begin
			st_next.cnt = '0;
		end else if (st_reg.cnt ==
			sbcint_pkg::CFG_FILT_CYC - 1'b1) begin
			st_next.lvl = i_pin;
			st_next.cnt = '0;
		end else begin
			st_next.cnt = st_reg.cnt + 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st_reg <= '{cnt: '0, lvl: sbcint_pkg::CFG_LVL_RST};
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_cfg_lvl = st_reg.lvl;

endmodule : sbcint_cfg_filt

// ---- rtl/sbcint_irq.sv ----
/*
 * Interrupt output of the system basis chip: latches wake and
 * failure events, drives the push-pull low pulse with its gap,
 * and samples the pin for the hardware setting in init mode.
 * Assumes mode levels and host read-clear pulses come from the
 * mode and serial port logic, all synchronous to i_ref_clk.
 */
`timescale 1ns/10ps
module sbcint_irq (
	// clock and reset
	input  wire logic                          i_ref_clk,
	input  wire logic                          i_reset_n,
	// operating mode
	input  wire logic                          i_init_mode,
	input  wire logic                          i_normal_mode,
	input  wire logic                          i_stop_mode,
	input  wire logic                          i_stop_cmd,
	// configuration
	input  wire logic                          i_int_global,
	input  wire logic [1:0]                    i_wake_filt_sel,
	input  wire logic                          i_cyc_t1,
	input  wire logic                          i_cyc_t2,
	input  wire logic [sbcint_pkg::WAKE_A_W-1:0] i_wake_en,
	input  wire logic [sbcint_pkg::WAKE_B_W-1:0] i_gp_wake_cfg,
	// wake inputs and failure events
	input  wire logic [sbcint_pkg::WAKE_N-1:0] i_wake_pin,
	input  wire logic [sbcint_pkg::FAIL_W-1:0] i_fail_evt,
	// host read and clear
	input  wire logic                          i_clr_wake_a,
	input  wire logic                          i_clr_wake_b,
	input  wire logic                          i_clr_fail,
	// status
	output logic [sbcint_pkg::WAKE_A_W-1:0]    o_wake_status_a,
	output logic [sbcint_pkg::WAKE_B_W-1:0]    o_wake_status_b,
	output logic [sbcint_pkg::FAIL_W-1:0]      o_fail_status,
	output logic [sbcint_pkg::WAKE_N-1:0]      o_input_level_status,
	output logic                               o_hw_cfg,
	// interrupt pin
	input  wire logic                          i_int_pin,
	output logic                               o_int_n,
	output logic                               o_int_oe_n
);
	localparam int AW = sbcint_pkg::WAKE_A_W;
	localparam int BW = sbcint_pkg::WAKE_B_W;
	localparam int FW = sbcint_pkg::FAIL_W;
	localparam int CW = sbcint_pkg::CNT_W;

	// ********************************************
	// state
	// ********************************************
	typedef struct packed {
		sbcint_pkg::sbcint_st_e st;
		logic [CW-1:0]          cnt;
		logic                   pend;
		logic [AW-1:0]          wa;
		logic [BW-1:0]          wb;
		logic [FW-1:0]          fl;
		logic [AW-1:0]          wa_vis;
		logic [BW-1:0]          wb_vis;
		logic [FW-1:0]          fl_vis;
		logic                   int_n;
		logic                   oe_n;
	} sbcint_irq_s;

	sbcint_irq_s st_reg;
	sbcint_irq_s st_next;

	logic          active;
	logic          start;
	logic [AW-1:0] wa_new;
	logic [BW-1:0] wb_new;
	logic [FW-1:0] fl_new;
	logic          trig;

	// ********************************************
	// submodules
	// ********************************************
	sbcint_wake_if wk ();

	assign wk.filt_sel = i_wake_filt_sel;
	assign wk.cyc_t1   = i_cyc_t1;
	assign wk.cyc_t2   = i_cyc_t2;
	assign wk.pin      = i_wake_pin;

	sbcint_wake_filt u_wake_filt (
		.i_ref_clk (i_ref_clk),
		.i_reset_n (i_reset_n),
		.wk        (wk.filt)
	);

	sbcint_cfg_filt u_cfg_filt (
		.i_ref_clk   (i_ref_clk),
		.i_reset_n   (i_reset_n),
		.i_init_mode (i_init_mode),
		.i_pin       (i_int_pin),
		.o_cfg_lvl   (o_hw_cfg)
	);

	// ********************************************
	// event qualification
	// ********************************************
	// mode is only read here, never driven back
	assign active = (i_normal_mode | i_stop_mode) & ~i_init_mode;

	// non-enabled wake sources are not stored at all; failure events are always stored
	assign wa_new = wk.evt[AW-1:0] & i_wake_en;
	assign wb_new = wk.evt[AW+BW-1:AW] & i_gp_wake_cfg;
	assign fl_new = i_fail_evt;

	// level status is never part of the trigger
	assign trig = (|wa_new) | (|wb_new)
		| (i_int_global & |(fl_new & ~sbcint_pkg::FAIL_NOINT_MASK))
		| (i_stop_cmd & (|st_reg.wa | |st_reg.wb));

	assign start = active & (st_reg.st == sbcint_pkg::ST_IDLE)
		& (st_reg.pend | trig);

	// ********************************************
	// next state
	// ********************************************
	always_comb begin
		st_next = st_reg;
		// hardware set wins over a clear in the same cycle
		st_next.wa = (st_reg.wa & ~({AW{i_clr_wake_a}} & st_reg.wa_vis))
			| wa_new;
		st_next.wb = (st_reg.wb & ~({BW{i_clr_wake_b}} & st_reg.wb_vis))
			| wb_new;
		st_next.fl = (st_reg.fl & ~({FW{i_clr_fail}} & st_reg.fl_vis))
			| fl_new;

		if (i_clr_wake_a) st_next.wa_vis = '0;
		if (i_clr_wake_b) st_next.wb_vis = '0;
		if (i_clr_fail) st_next.fl_vis = '0;

		// held until the next pulse starts
		if (trig) st_next.pend = 1'b1;

		case (st_reg.st)
			sbcint_pkg::ST_IDLE: begin
				if (start) begin
					st_next.st     = sbcint_pkg::ST_PULSE;
					st_next.cnt    = sbcint_pkg::PULSE_CYC - 1'b1;
					st_next.pend   = 1'b0;
					st_next.wa_vis = st_next.wa;
					st_next.wb_vis = st_next.wb;
					st_next.fl_vis = st_next.fl;
				end
			end
			sbcint_pkg::ST_PULSE: begin
				if (st_reg.cnt == '0) begin
					st_next.st  = sbcint_pkg::ST_GAP;
					st_next.cnt = sbcint_pkg::GAP_CYC - 1'b1;
				end else begin
					st_next.cnt = st_reg.cnt - 1'b1;
				end
			end
			sbcint_pkg::ST_GAP: begin
				if (st_reg.cnt == '0) begin
					st_next.st = sbcint_pkg::ST_IDLE;
				end else begin
					st_next.cnt = st_reg.cnt - 1'b1;
				end
			end
			default: begin
				st_next.st = sbcint_pkg::ST_IDLE;
			end
		endcase

		// init mode owns the pin for configuration sampling
		if (i_init_mode) begin
			st_next.st = sbcint_pkg::ST_IDLE;
		end
		st_next.int_n = (st_next.st != sbcint_pkg::ST_PULSE);
		st_next.oe_n  = i_init_mode;
	end

	// ********************************************
	// registers
	// ********************************************
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st_reg <= '{st: sbcint_pkg::ST_IDLE, cnt: '0, pend: 1'b0,
				wa: '0, wb: '0, fl: sbcint_pkg::FAIL_RST,
				wa_vis: '0, wb_vis: '0, fl_vis: sbcint_pkg::FAIL_RST,
				int_n: 1'b1, oe_n: 1'b1};
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_wake_status_a      = st_reg.wa_vis;
	assign o_wake_status_b      = st_reg.wb_vis;
	assign o_fail_status        = st_reg.fl_vis;
	assign o_input_level_status = wk.lvl;
	assign o_int_n              = st_reg.int_n;
	assign o_int_oe_n           = st_reg.oe_n;

	// ********************************************
	// checks
	// ********************************************
	localparam int PULSE_N = int'(sbcint_pkg::PULSE_CYC);
	localparam int GAP_N   = int'(sbcint_pkg::GAP_CYC);

	logic [CW-1:0] lo_cnt;
	logic [CW-1:0] hi_cnt;

	// low and high run lengths of the pin, for timing checks
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			lo_cnt <= '0;
			hi_cnt <= sbcint_pkg::GAP_CYC;
		end else begin
			lo_cnt <= o_int_n ? '0 : lo_cnt + 1'b1;
			hi_cnt <= !o_int_n ? '0 :
				(hi_cnt == sbcint_pkg::GAP_CYC ? hi_cnt : hi_cnt + 1'b1);
		end
	end

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_reset_n);

	AST_PULSE_WIDTH: assert property (
		$rose(o_int_n) && $past(!i_init_mode) |->
			int'(lo_cnt) == PULSE_N)
		else $error("interrupt pulse width wrong");

	AST_MIN_GAP: assert property (
		$fell(o_int_n) |-> int'(hi_cnt) >= GAP_N)
		else $error("interrupt gap too short");

	// run length is kept apart from the state, so a stuck low shows
	AST_IDLE_HIGH: assert property (
		!o_int_n |-> int'(lo_cnt) < PULSE_N)
		else $error("pin low longer than a pulse");

	AST_INIT_RELEASE: assert property (
		i_init_mode |=> o_int_oe_n && o_int_n)
		else $error("pin driven during init mode");

	AST_PUSH_PULL: assert property (
		!i_init_mode ##1 !i_init_mode |-> !o_int_oe_n)
		else $error("pin not driven outside init");

	AST_STOP_ENTRY: assert property (
		i_stop_cmd && (|st_reg.wa || |st_reg.wb) |=>
			st_reg.pend || $fell(o_int_n))
		else $error("stop entry with wake bits gave no pulse");

	AST_SNAPSHOT: assert property (
		o_wake_status_a != $past(o_wake_status_a) |->
			$fell(o_int_n) || $past(i_clr_wake_a))
		else $error("status changed without pulse or clear");

	AST_LATCH_HOLD: assert property (
		!i_clr_wake_a && !i_clr_fail |=>
			((st_reg.wa & $past(st_reg.wa)) == $past(st_reg.wa))
			&& ((st_reg.fl & $past(st_reg.fl)) == $past(st_reg.fl)))
		else $error("latched event lost without clear");

	AST_CLASS: assert property (
		!i_int_global && !i_stop_cmd && wk.evt == '0 && !st_reg.pend
		|=> !st_reg.pend)
		else $error("interrupt from failure in wake class");

	COV_PULSE: cover property (
		$rose(o_int_n) && int'(lo_cnt) == PULSE_N);
	COV_BACK_TO_BACK: cover property (
		st_reg.pend && st_reg.st == sbcint_pkg::ST_GAP);
	COV_STOP_PULSE: cover property (
		i_stop_cmd && (|st_reg.wa || |st_reg.wb) ##1 !o_int_n);
	COV_CLEAR_RACE: cover property (
		i_clr_wake_a && (|wa_new));

endmodule : sbcint_irq

// ---- tb/sbcint_host_model.sv ----
/*
 * Host-side model of the interrupt pin: straps the pin while the
 * device releases it and measures low pulses and high gaps.
 * Assumes the pin level is settled at each reference clock edge.
 */
`timescale 1ns/10ps
module sbcint_host_model (
	// clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_reset_n,
	// pin
	input  wire logic        i_int_lvl,
	input  wire logic        i_released,
	input  wire logic        i_strap,
	output logic             o_pin_drv,
	// measurements
	output logic [15:0]      o_low_cyc,
	output logic [15:0]      o_gap_cyc,
	output logic [15:0]      o_pulses
);
	logic        prev_reg;
	logic [15:0] run_reg;

	// strap resistor when high, else only the config pull-down
	assign o_pin_drv = i_strap;

	// ********************************************
	// pulse and gap measurement
	// ********************************************
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			prev_reg  <= 1'b1;
			run_reg   <= 16'h0000;
			o_low_cyc <= 16'h0000;
			o_gap_cyc <= 16'h0000;
			o_pulses  <= 16'h0000;
		end else if (i_released) begin
			prev_reg <= 1'b1;
			run_reg  <= 16'h0000;
		end else if (i_int_lvl != prev_reg) begin
			prev_reg <= i_int_lvl;
			run_reg  <= 16'h0001;
			if (i_int_lvl) begin
				o_low_cyc <= run_reg;
			end else begin
				o_gap_cyc <= run_reg;
				o_pulses  <= o_pulses + 16'h0001;
			end
		end else begin
			run_reg <= run_reg + 16'h0001;
		end
	end
endmodule : sbcint_host_model

// ---- tb/sbcint_irq_tb_top.sv ----
/*
 * Self-checking bench of the interrupt output block.
 * Assumes a 25 MHz clock and the host model on the pin.
 */
`timescale 1ns/10ps
module sbcint_irq_tb_top;
	localparam int CYC_LIMIT = 40000;
	logic        i_ref_clk, i_reset_n, i_init_mode, i_normal_mode;
	logic        i_stop_mode, i_stop_cmd, i_int_global, i_cyc_t1;
	logic        i_cyc_t2, i_clr_wake_a, i_clr_wake_b, i_clr_fail;
	logic [1:0]  i_wake_filt_sel, i_gp_wake_cfg, o_wake_status_b;
	logic [2:0]  i_wake_en, o_wake_status_a;
	logic [4:0]  i_wake_pin, o_input_level_status;
	logic [7:0]  i_fail_evt, o_fail_status;
	logic        o_hw_cfg, i_int_pin, o_int_n, o_int_oe_n;
	logic        strap, pin_drv;
	logic [15:0] low_cyc, gap_cyc, pulses, p;
	logic [31:0] rnd;
	int          n_fail, samples_checked, cyc_cnt, idx, b;

	sbcint_irq dut_u (.i_ref_clk, .i_reset_n, .i_init_mode,
		.i_normal_mode, .i_stop_mode, .i_stop_cmd, .i_int_global,
		.i_wake_filt_sel, .i_cyc_t1, .i_cyc_t2, .i_wake_en,
		.i_gp_wake_cfg, .i_wake_pin, .i_fail_evt, .i_clr_wake_a,
		.i_clr_wake_b, .i_clr_fail, .o_wake_status_a,
		.o_wake_status_b, .o_fail_status, .o_input_level_status,
		.o_hw_cfg, .i_int_pin, .o_int_n, .o_int_oe_n);

	sbcint_host_model host_u (.i_ref_clk, .i_reset_n,
		.i_int_lvl(i_int_pin), .i_released(o_int_oe_n),
		.i_strap(strap), .o_pin_drv(pin_drv), .o_low_cyc(low_cyc),
		.o_gap_cyc(gap_cyc), .o_pulses(pulses));

	// released pin follows the host strap
	assign i_int_pin = o_int_oe_n ? pin_drv : o_int_n;

	// ********************************************
	// helpers
	// ********************************************
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xorshift

	function automatic logic [7:0] bit_at(input int i);
		return 8'h01 << i;
	endfunction : bit_at

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h",
				$time, got, exp);
		end
	endtask : chk

	task automatic step(input int n);
		repeat (n) @(posedge i_ref_clk);
		#2;
	endtask : step

	// bounded wait, the level itself is then compared
	task automatic wait_lvl(input logic lvl, input int lim);
		int k;
		k = 0;
		while (o_int_n !== lvl && k < lim) begin
			step(1);
			k++;
		end
		chk(16'(o_int_n), 16'(lvl));
	endtask : wait_lvl

	task automatic conclude();
		if (n_fail == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : conclude

	initial begin
		i_ref_clk = 1'b0;
		forever #20 i_ref_clk = ~i_ref_clk;
	end

	always @(posedge i_ref_clk) begin
		cyc_cnt++;
		if (cyc_cnt == CYC_LIMIT) begin
			n_fail++;
			conclude();
		end
	end

	// ********************************************
	// scenarios
	// ********************************************
	initial begin
		{i_normal_mode, i_stop_mode, i_stop_cmd, i_int_global} = 4'h0;
		{i_cyc_t1, i_cyc_t2, i_clr_wake_a, i_clr_wake_b} = 4'h0;
		{i_clr_fail, i_wake_filt_sel, i_wake_pin} = 8'h00;
		i_fail_evt = 8'h00;
		i_reset_n = 1'b0;
		i_init_mode = 1'b1;
		strap = 1'b1;
		i_wake_en = 3'h5;
		i_gp_wake_cfg = 2'h1;
		rnd = 32'h0000_8AB5;
		step(16);
		chk(16'(o_int_n), 16'h0001);
		chk(16'(o_wake_status_a), 16'h0000);
		i_reset_n = 1'b1;
		step(2);
		chk(16'(o_int_oe_n), 16'h0001);
		step(100);
		chk(16'(o_hw_cfg), 16'h0000);
		step(100);
		chk(16'(o_hw_cfg), 16'h0001);
		i_init_mode = 1'b0;
		i_normal_mode = 1'b1;
		strap = 1'b0;
		step(2);
		chk(16'(o_int_oe_n), 16'h0000);
		rnd = xorshift(rnd);
		idx = rnd[0] ? 2 : 0;
		i_wake_pin[idx] = 1'b1;
		step(395);
		chk(16'(o_int_n), 16'h0001);
		wait_lvl(1'b0, 20);
		chk(16'(o_wake_status_a), 16'(bit_at(idx)));
		chk(16'(o_input_level_status[idx]), 16'h0001);
		i_wake_pin[4:3] = 2'h3;
		i_wake_pin[1] = 1'b1;
		wait_lvl(1'b1, 2600);
		step(1);
		chk(low_cyc, 16'(sbcint_pkg::PULSE_CYC));
		chk(16'(o_wake_status_b), 16'h0000);
		wait_lvl(1'b0, 2600);
		step(1);
		chk(gap_cyc, 16'(sbcint_pkg::GAP_CYC) + 16'h0001);
		chk(16'(o_hw_cfg), 16'h0001);
		chk(16'(o_wake_status_b), 16'h0001);
		chk(16'(o_wake_status_a), 16'(bit_at(idx)));
		wait_lvl(1'b1, 2600);
		i_clr_wake_a = 1'b1;
		step(1);
		i_clr_wake_a = 1'b0;
		chk(16'(o_wake_status_a), 16'h0000);
		step(5);
		chk(16'(o_wake_status_a), 16'h0000);
		chk(16'(o_wake_status_b), 16'h0001);
		step(2600);
		{i_normal_mode, i_stop_mode, i_stop_cmd} = 3'h3;
		step(1);
		i_stop_cmd = 1'b0;
		wait_lvl(1'b0, 3);
		wait_lvl(1'b1, 2600);
		{i_clr_wake_b, i_clr_fail} = 2'h3;
		step(1);
		{i_clr_wake_b, i_clr_fail} = 2'h0;
		p = pulses;
		i_fail_evt = 8'h40;
		step(1);
		i_fail_evt = 8'h00;
		step(3000);
		chk(pulses, p);
		i_int_global = 1'b1;
		i_fail_evt = sbcint_pkg::FAIL_NOINT_MASK;
		step(1);
		i_fail_evt = 8'h00;
		step(3000);
		chk(pulses, p);
		rnd = xorshift(rnd);
		b = 5 + int'(rnd % 3);
		i_fail_evt = bit_at(b);
		step(1);
		i_fail_evt = 8'h00;
		wait_lvl(1'b0, 3);
		chk(16'(o_fail_status[b]), 16'h0001);
		i_wake_filt_sel = sbcint_pkg::FLT_STATIC_LONG;
		i_wake_pin[idx] = 1'b0;
		step(1000);
		chk(16'(o_input_level_status[idx]), 16'h0001);
		step(700);
		chk(16'(o_input_level_status[idx]), 16'h0000);
		i_wake_filt_sel = sbcint_pkg::FLT_CYCLIC_T1;
		i_wake_pin[3] = 1'b0;
		step(500);
		chk(16'(o_input_level_status[3]), 16'h0001);
		i_cyc_t1 = 1'b1;
		step(420);
		chk(16'(o_input_level_status[3]), 16'h0000);
		// second cyclic timer: holds while its on-time is low
		i_wake_filt_sel = sbcint_pkg::FLT_CYCLIC_T2;
		i_wake_pin[3] = 1'b1;
		step(500);
		chk(16'(o_input_level_status[3]), 16'h0000);
		i_cyc_t2 = 1'b1;
		step(420);
		chk(16'(o_input_level_status[3]), 16'h0001);
		conclude();
	end
endmodule : sbcint_irq_tb_top
